// [logic/enc_cmd_regs.svh]
`ifndef ENC_CMD_REGS_SVH
`define ENC_CMD_REGS_SVH
// ==========================================================
// register byte offsets
`define REG_CMD        8'h00
`define REG_PARAM      8'h04
`define REG_STATUS     8'h08
`define REG_REPLY      8'h0c
`define REG_POSITION   8'h10
`define REG_RESOLUTION 8'h14
`define REG_ENC_TYPE   8'h18
`define REG_DENOM      8'h1c
`define REG_AFUNC      8'h20
// ==========================================================
// command register fields
`define CMD_OP_LSB     0
`define CMD_OP_MSB     2
`define CMD_HAS_PARAM  8
`define CMD_CHAN_LSB   16
`define CMD_CHAN_MSB   17
// status register fields
`define STS_REPLY_VALID 0
`define STS_REJECT      1
// ==========================================================
// accepted ranges and reset values
`define POS_FORBIDDEN  32'h8000_0000
`define RES_MIN        32'h0000_00c8
`define RES_MAX        32'h0001_f400
`define DENOM_MAX      32'h0000_03e8
`define RES_RESET      18'h00fa0
`define DENOM_RESET    10'h3e8
`define AFUNC_RESET    2'h3
`define AFUNC_MIN      2'h1
`define AFUNC_MAX      2'h3
`endif

// [logic/enc_cmd_pkg.sv]
package enc_cmd_pkg;
   typedef enum logic [2:0] {
      op_none          = 3'h0,
      op_encoder_pos   = 3'h1,
      op_resolution    = 3'h2,
      op_encoder_type  = 3'h3,
      op_gear_denom    = 3'h4,
      op_analog_func   = 3'h5
   } op_t;

   typedef struct packed {
      logic [31:0] pos;
      logic [17:0] res;
      logic        single_ended;
      logic [9:0]  denom;
      logic [1:0]  afunc1;
      logic [1:0]  afunc2;
      logic        gear_en;
      logic        analog_input_one_ref;
      logic        analog_input_one_gp;
      logic        analog_input_two_trq;
      logic        analog_input_two_gp;
      logic [31:0] param;
      logic [31:0] reply;
      logic        reply_valid;
      logic        reject;
      logic        waitreq;
      logic [31:0] rdata;
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic [1:0]  ab_prev;
   } state_t;
endpackage

// [logic/reset_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
   input  wire logic i_clk,
   input  wire logic i_resetn,
   output logic      o_rst_n
);
   logic stage_q;

   // release is synchronous so no flop sees reset drop near its edge
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         stage_q <= 1'b0;
         o_rst_n <= 1'b0;
      end else begin
         stage_q <= 1'b1;
         o_rst_n <= stage_q;
      end
   end
endmodule // reset_sync
`default_nettype wire

// [logic/encoder_gearing_command_handler.sv]
// How it works
// - position command with value loads the signed encoder count, within limits.
// - position command without value reports the present encoder count.
// - resolution command stores counts per rev, 200 to 128000, queryable.
// - encoder type flag zero selects differential, one selects single-ended.
// - gear denominator stores 0 to 1000, default 1000.
// - denominator zero disables electronic gearing.
// - analog function takes channel 1 or 2 and code 1 to 3, default 3.
// - channel one code 1 is reference, 2 unused, 3 general purpose.
// - channel two code 1 unused, 2 torque reference, 3 general purpose.
// - analog function with only a channel replies that channel's code.
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "enc_cmd_regs.svh"
module encoder_gearing_command_handler (
   input  wire logic        i_clk_sys,
   input  wire logic        i_resetn,
   // avalon-mm slave
   input  wire logic [7:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest,
   // encoder pins, both flavours
   input  wire logic        i_enc_a_diff,
   input  wire logic        i_enc_b_diff,
   input  wire logic        i_enc_a_se,
   input  wire logic        i_enc_b_se,
   // settings seen by the drive
   output logic [31:0]      o_position,
   output logic [17:0]      o_resolution,
   output logic             o_enc_single_ended,
   output logic [9:0]       o_gear_denom,
   output logic             o_gear_enable,
   output logic             o_analog_input_one_is_reference,
   output logic             o_analog_input_one_is_general,
   output logic             o_analog_input_two_is_torque,
   output logic             o_analog_input_two_is_general
);
   // ==========================================================
   // reset
   logic rst_n;

   reset_sync u_reset_sync (
      .i_clk    (i_clk_sys),
      .i_resetn (i_resetn),
      .o_rst_n  (rst_n)
   );

   enc_cmd_pkg::state_t s_q;
   enc_cmd_pkg::state_t s_d;

   // ==========================================================
   // bus decode
   logic                req;
   logic                wr_cmd;
   logic                exec;
   enc_cmd_pkg::op_t    op;
   logic                has_param;
   logic [1:0]          chan;
   logic                val_ok;
   logic signed [31:0]  pv;

   // a request is taken once, in the cycle while waitrequest is high
   assign req       = (i_read | i_write) & s_q.waitreq;
   assign wr_cmd    = req & i_write & (i_address == `REG_CMD);
   assign op        = enc_cmd_pkg::op_t'(
                         i_writedata[`CMD_OP_MSB:`CMD_OP_LSB]);
   assign has_param = i_writedata[`CMD_HAS_PARAM];
   assign chan      = i_writedata[`CMD_CHAN_MSB:`CMD_CHAN_LSB];
   assign exec      = wr_cmd;
   assign pv        = s_q.param;

   function automatic logic afunc_ok(input logic [31:0] v);
      afunc_ok = (v >= {30'h0, `AFUNC_MIN}) && (v <= {30'h0, `AFUNC_MAX});
   endfunction

   // range check for the command being issued; a query carries no
   // value, so a stale parameter word must not refuse it
   always_comb begin
      case (op)
         enc_cmd_pkg::op_encoder_pos:
            val_ok = !has_param
                     || (s_q.param != `POS_FORBIDDEN);
         enc_cmd_pkg::op_resolution:
            val_ok = !has_param
                     || ((pv >= `RES_MIN) && (pv <= `RES_MAX));
         enc_cmd_pkg::op_encoder_type:
            val_ok = !has_param
                     || (s_q.param[31:1] == 31'h0);
         enc_cmd_pkg::op_gear_denom:
            val_ok = !has_param
                     || ((pv >= 32'sh0) && (pv <= `DENOM_MAX));
         enc_cmd_pkg::op_analog_func:
            val_ok = (chan == 2'h1 || chan == 2'h2)
                     && (!has_param || afunc_ok(s_q.param));
         default:
            val_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // next state
   logic [1:0] ab_now;
   logic       moved;
   logic       up;

   always_comb begin
      s_d = s_q;

      // pins pass two flops; the first stage feeds only the second
      s_d.sync1 = {i_enc_a_diff, i_enc_b_diff, i_enc_a_se, i_enc_b_se};
      s_d.sync2 = s_q.sync1;
      ab_now = s_q.single_ended ? s_q.sync2[1:0]
                                : s_q.sync2[3:2];
      s_d.ab_prev = ab_now;
      // a double step is a glitch or overspeed; it is dropped
      moved = (ab_now[0] != s_q.ab_prev[0])
              ^ (ab_now[1] != s_q.ab_prev[1]);
      up = ab_now[1] ^ s_q.ab_prev[0];
      if (moved) begin
         s_d.pos = up ? s_q.pos + 32'h1 : s_q.pos - 32'h1;
      end

      // bus handshake: one cycle of waitrequest low per request
      s_d.waitreq = 1'b1;
      if (req) begin
         s_d.waitreq = 1'b0;
      end

      // reads
      if (req && i_read) begin
         if (i_address == `REG_PARAM) begin
            s_d.rdata = s_q.param;
         end else if (i_address == `REG_STATUS) begin
            s_d.rdata = {30'h0, s_q.reject, s_q.reply_valid};
         end else if (i_address == `REG_REPLY) begin
            s_d.rdata = s_q.reply;
         end else if (i_address == `REG_POSITION) begin
            s_d.rdata = s_q.pos;
         end else if (i_address == `REG_RESOLUTION) begin
            s_d.rdata = {14'h0, s_q.res};
         end else if (i_address == `REG_ENC_TYPE) begin
            s_d.rdata = {31'h0, s_q.single_ended};
         end else if (i_address == `REG_DENOM) begin
            s_d.rdata = {22'h0, s_q.denom};
         end else if (i_address == `REG_AFUNC) begin
            s_d.rdata = {22'h0, s_q.afunc2, 6'h0, s_q.afunc1};
         end else begin
            s_d.rdata = 32'h0;
         end
      end

      // writes other than commands
      if (req && i_write) begin
         if (i_address == `REG_PARAM) begin
            s_d.param = i_writedata;
         end else if (i_address == `REG_STATUS) begin
            // write one to clear; a same-cycle set below wins
            if (i_writedata[`STS_REPLY_VALID]) begin
               s_d.reply_valid = 1'b0;
            end
            if (i_writedata[`STS_REJECT]) begin
               s_d.reject = 1'b0;
            end
         end
      end

      // command execution
      if (exec && !val_ok) begin
         s_d.reject = 1'b1;
      end else if (exec && !has_param
                   && op != enc_cmd_pkg::op_analog_func) begin
         s_d.reply_valid = 1'b1;
         case (op)
            enc_cmd_pkg::op_encoder_pos:
               s_d.reply = s_q.pos;
            enc_cmd_pkg::op_resolution:
               s_d.reply = {14'h0, s_q.res};
            enc_cmd_pkg::op_encoder_type:
               s_d.reply = {31'h0, s_q.single_ended};
            default:
               s_d.reply = {22'h0, s_q.denom};
         endcase
      end else if (exec && !has_param) begin
         s_d.reply_valid = 1'b1;
         s_d.reply = {30'h0, (chan == 2'h1) ? s_q.afunc1
                                            : s_q.afunc2};
      end else if (exec) begin
         case (op)
            enc_cmd_pkg::op_encoder_pos:
               s_d.pos = s_q.param;
            enc_cmd_pkg::op_resolution:
               s_d.res = s_q.param[17:0];
            enc_cmd_pkg::op_encoder_type:
               s_d.single_ended = s_q.param[0];
            enc_cmd_pkg::op_gear_denom:
               s_d.denom = s_q.param[9:0];
            default: begin
               if (chan == 2'h1) begin
                  s_d.afunc1 = s_q.param[1:0];
               end else begin
                  s_d.afunc2 = s_q.param[1:0];
               end
            end
         endcase
      end

      // decoded settings registered so outputs come from flops
      s_d.gear_en  = (s_d.denom != 10'h0);
      s_d.analog_input_one_ref = (s_d.afunc1 == 2'h1);
      s_d.analog_input_one_gp  = (s_d.afunc1 == 2'h3);
      s_d.analog_input_two_trq = (s_d.afunc2 == 2'h2);
      s_d.analog_input_two_gp  = (s_d.afunc2 == 2'h3);
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q              <= '0;
         s_q.res          <= `RES_RESET;
         s_q.denom        <= `DENOM_RESET;
         s_q.afunc1       <= `AFUNC_RESET;
         s_q.afunc2       <= `AFUNC_RESET;
         s_q.gear_en      <= 1'b1;
         s_q.analog_input_one_gp      <= 1'b1;
         s_q.analog_input_two_gp      <= 1'b1;
         s_q.waitreq      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign o_readdata          = s_q.rdata;
   assign o_waitrequest       = s_q.waitreq;
   assign o_position          = s_q.pos;
   assign o_resolution        = s_q.res;
   assign o_enc_single_ended  = s_q.single_ended;
   assign o_gear_denom        = s_q.denom;
   assign o_gear_enable       = s_q.gear_en;
   assign o_analog_input_one_is_reference = s_q.analog_input_one_ref;
   assign o_analog_input_one_is_general   = s_q.analog_input_one_gp;
   assign o_analog_input_two_is_torque    = s_q.analog_input_two_trq;
   assign o_analog_input_two_is_general   = s_q.analog_input_two_gp;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n);

   pos_load_a: assert property (
      exec && op == enc_cmd_pkg::op_encoder_pos && has_param && val_ok
      |=> o_position == $past(s_q.param))
      else $error("position not loaded from value");

   pos_query_a: assert property (
      exec && op == enc_cmd_pkg::op_encoder_pos && !has_param
      |=> s_q.reply_valid && s_q.reply == $past(o_position))
      else $error("position query gave wrong reply");

   res_range_a: assert property (
      o_resolution >= 18'h000c8 && o_resolution <= 18'h1f400)
      else $error("resolution outside legal range");

   type_set_a: assert property (
      exec && op == enc_cmd_pkg::op_encoder_type && has_param && val_ok
      |=> o_enc_single_ended == $past(s_q.param[0]))
      else $error("encoder type not taken");

   denom_range_a: assert property (
      o_gear_denom <= 10'h3e8)
      else $error("denominator above 1000");

   gear_off_a: assert property (
      o_gear_enable == (o_gear_denom != 10'h0))
      else $error("gearing enable disagrees with denominator");

   analog_input_one_map_a: assert property (
      o_analog_input_one_is_reference == (s_q.afunc1 == 2'h1)
      && o_analog_input_one_is_general == (s_q.afunc1 == 2'h3))
      else $error("channel one function wrongly decoded");

   analog_input_two_map_a: assert property (
      o_analog_input_two_is_torque == (s_q.afunc2 == 2'h2)
      && o_analog_input_two_is_general == (s_q.afunc2 == 2'h3))
      else $error("channel two function wrongly decoded");

   afunc_query_a: assert property (
      exec && op == enc_cmd_pkg::op_analog_func && !has_param && val_ok
      |=> s_q.reply[1:0] == ($past(chan) == 2'h1 ? s_q.afunc1
                                                  : s_q.afunc2))
      else $error("analog function query gave wrong code");

   reject_keep_a: assert property (
      exec && !val_ok
      |=> s_q.reject && $stable(o_resolution) && $stable(o_gear_denom)
          && $stable(s_q.afunc1) && $stable(s_q.afunc2))
      else $error("rejected value changed a setting");

   res_load_a: assert property (
      exec && op == enc_cmd_pkg::op_resolution && has_param && val_ok
      |=> o_resolution == $past(s_q.param[17:0]))
      else $error("resolution not loaded from value");

   res_query_a: assert property (
      exec && op == enc_cmd_pkg::op_resolution && !has_param
      |=> s_q.reply_valid && s_q.reply == {14'h0, $past(o_resolution)})
      else $error("resolution query gave wrong reply");

   denom_load_a: assert property (
      exec && op == enc_cmd_pkg::op_gear_denom && has_param && val_ok
      |=> o_gear_denom == $past(s_q.param[9:0]))
      else $error("denominator not loaded from value");

   gear_follow_a: assert property (
      exec && op == enc_cmd_pkg::op_gear_denom && has_param && val_ok
      && s_q.param == 32'h0 |=> !o_gear_enable)
      else $error("zero denominator left gearing on");

   afunc_set_a: assert property (
      exec && op == enc_cmd_pkg::op_analog_func && has_param && val_ok
      |=> ($past(chan) == 2'h1 ? s_q.afunc1 : s_q.afunc2)
          == $past(s_q.param[1:0]))
      else $error("analog function code not stored");

   afunc_legal_a: assert property (
      s_q.afunc1 != 2'h0 && s_q.afunc2 != 2'h0)
      else $error("analog function code zero stored");

   count_step_a: assert property (
      !(exec && op == enc_cmd_pkg::op_encoder_pos && has_param && val_ok)
      |=> o_position == $past(o_position)
          || o_position == $past(o_position) + 32'h1
          || o_position == $past(o_position) - 32'h1)
      else $error("position moved by more than one count");

endmodule // encoder_gearing_command_handler
`default_nettype wire

// [dv/quad_encoder_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// quadrature encoder with a differential and a single-ended pair
module quad_encoder_model (
   input  wire logic i_clk,
   input  wire logic i_step,
   input  wire logic i_up,
   input  wire logic i_single_ended,
   output logic      o_a_diff,
   output logic      o_b_diff,
   output logic      o_a_se,
   output logic      o_b_se
);
   logic [1:0] ph_diff_q = 2'h0;
   logic [1:0] ph_se_q   = 2'h0;
   logic [1:0] div_q     = 2'h0;
   // the pair not in use keeps turning, so a counter that listens to
   // the wrong pair shows up as drift in the count
   always_ff @(posedge i_clk) begin
      div_q <= div_q + 2'h1;
      if (i_single_ended) begin
         if (i_step) ph_se_q <= i_up ? ph_se_q + 2'h1 : ph_se_q - 2'h1;
         if (div_q == 2'h3) ph_diff_q <= ph_diff_q + 2'h1;
      end else begin
         if (i_step) ph_diff_q <= i_up ? ph_diff_q + 2'h1 : ph_diff_q - 2'h1;
         if (div_q == 2'h3) ph_se_q <= ph_se_q + 2'h1;
      end
   end
   // phase order 00, 10, 11, 01: a leads b when counting up
   assign o_a_diff = ph_diff_q[0] ^ ph_diff_q[1];
   assign o_b_diff = ph_diff_q[1];
   assign o_a_se   = ph_se_q[0] ^ ph_se_q[1];
   assign o_b_se   = ph_se_q[1];
endmodule // quad_encoder_model
`default_nettype wire

// [dv/encoder_gearing_command_handler_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "enc_cmd_regs.svh"
module encoder_gearing_command_handler_tb;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  address = 8'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        step = 1'b0;
   logic        up = 1'b1;
   logic        se = 1'b0;
   logic        a_d, b_d, a_s, b_s;
   logic [31:0] position;
   logic [17:0] resolution;
   logic        single_ended, gear_enable;
   logic [9:0]  gear_denom;
   logic        analog_input_one_ref, analog_input_one_gp, analog_input_two_trq, analog_input_two_gp;
   logic [31:0] rdat;
   logic [1:0]  af1 = 2'h3;
   logic [1:0]  af2 = 2'h3;
   int          failures = 0;
   int          checks = 0;

   always #10 clk = ~clk;

   encoder_gearing_command_handler uut (
      .i_clk_sys(clk), .i_resetn(resetn), .i_address(address),
      .i_read(read), .i_write(write), .i_writedata(writedata),
      .o_readdata(readdata), .o_waitrequest(waitrequest),
      .i_enc_a_diff(a_d), .i_enc_b_diff(b_d), .i_enc_a_se(a_s),
      .i_enc_b_se(b_s), .o_position(position), .o_resolution(resolution),
      .o_enc_single_ended(single_ended), .o_gear_denom(gear_denom),
      .o_gear_enable(gear_enable), .o_analog_input_one_is_reference(analog_input_one_ref),
      .o_analog_input_one_is_general(analog_input_one_gp), .o_analog_input_two_is_torque(analog_input_two_trq),
      .o_analog_input_two_is_general(analog_input_two_gp)
   );

   quad_encoder_model enc (
      .i_clk(clk), .i_step(step), .i_up(up), .i_single_ended(se),
      .o_a_diff(a_d), .o_b_diff(b_d), .o_a_se(a_s), .o_b_se(b_s)
   );

   // ==========================================================
   // reporting
   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ==========================================================
   // avalon-mm master; waitrequest and readdata are read right after the
   // edge, before the design's flops update, so they are the edge values
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address   <= a;
      writedata <= d;
      read      <= !wr;
      write     <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) begin
         failures++;
         results();
      end
      rdat = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic do_cmd(input logic [2:0] op, input logic has,
                         input logic [1:0] ch, input logic [31:0] p);
      bus(1'b1, `REG_PARAM, p);
      bus(1'b1, `REG_CMD, {14'h0, ch, 7'h0, has, 5'h0, op});
   endtask

   task automatic reject_is(input logic exp);
      bus(1'b0, `REG_STATUS, 32'h0);
      check(rdat[1], exp);
      bus(1'b1, `REG_STATUS, 32'h3);
   endtask

   // set a value, read the setting back, then query it
   task automatic set_chk(input logic [2:0] op, input logic [7:0] a,
                          input logic [31:0] v, input logic ok,
                          input logic [31:0] old);
      logic [31:0] exp;
      exp = ok ? v : old;
      do_cmd(op, 1'b1, 2'h0, v);
      reject_is(!ok);
      bus(1'b0, a, 32'h0);
      check(rdat, exp);
      do_cmd(op, 1'b0, 2'h0, 32'h0);
      bus(1'b0, `REG_REPLY, 32'h0);
      check(rdat, exp);
      bus(1'b0, `REG_STATUS, 32'h0);
      check(rdat, 32'h1);
      bus(1'b1, `REG_STATUS, 32'h3);
   endtask

   task automatic turn(input int n, input logic dir);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         step <= 1'b1;
         up   <= dir;
         @(posedge clk);
         step <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      bus(1'b0, `REG_DENOM, 32'h0);
      check(rdat, 32'h3e8);
      check(gear_enable, 1'b1);
      bus(1'b0, `REG_AFUNC, 32'h0);
      check(rdat, 32'h303);
      check({analog_input_one_ref, analog_input_one_gp, analog_input_two_trq, analog_input_two_gp}, 4'h5);
      bus(1'b0, 8'h40, 32'h0);
      check(rdat, 32'h0);
      // no motion is running here; the counter is set and queried
      // with the encoder pair in use standing still
      set_chk(enc_cmd_pkg::op_encoder_pos, `REG_POSITION, 32'h7fff_ffff,
              1'b1, 32'h0);
      set_chk(enc_cmd_pkg::op_encoder_pos, `REG_POSITION, 32'h8000_0001,
              1'b1, 32'h0);
      set_chk(enc_cmd_pkg::op_encoder_pos, `REG_POSITION, 32'h8000_0000,
              1'b0, 32'h8000_0001);
      check(position, 32'h8000_0001);
      // counting on both feedback paths
      for (int t = 0; t < 2; t++) begin
         se <= t[0];
         do_cmd(enc_cmd_pkg::op_encoder_type, 1'b1, 2'h0, 32'(t));
         check(single_ended, t[0]);
         bus(1'b0, `REG_ENC_TYPE, 32'h0);
         check(rdat, 32'(t));
         repeat (8) @(posedge clk);
         do_cmd(enc_cmd_pkg::op_encoder_pos, 1'b1, 2'h0, 32'h10);
         turn(5, 1'b1);
         turn(3, 1'b0);
         do_cmd(enc_cmd_pkg::op_encoder_pos, 1'b0, 2'h0, 32'h0);
         bus(1'b0, `REG_REPLY, 32'h0);
         check(rdat, 32'h12);
         check(position, 32'h12);
      end
      set_chk(enc_cmd_pkg::op_encoder_type, `REG_ENC_TYPE, 32'h2,
              1'b0, 32'h1);
      set_chk(enc_cmd_pkg::op_resolution, `REG_RESOLUTION, 32'hc8,
              1'b1, 32'hfa0);
      set_chk(enc_cmd_pkg::op_resolution, `REG_RESOLUTION, 32'h1f400,
              1'b1, 32'hc8);
      set_chk(enc_cmd_pkg::op_resolution, `REG_RESOLUTION, 32'hc7,
              1'b0, 32'h1f400);
      set_chk(enc_cmd_pkg::op_resolution, `REG_RESOLUTION, 32'h1f401,
              1'b0, 32'h1f400);
      check(resolution, 18'h1f400);
      set_chk(enc_cmd_pkg::op_gear_denom, `REG_DENOM, 32'h0,
              1'b1, 32'h3e8);
      check(gear_enable, 1'b0);
      set_chk(enc_cmd_pkg::op_gear_denom, `REG_DENOM, 32'h3e8,
              1'b1, 32'h0);
      check({gear_enable, gear_denom}, 11'h7e8);
      set_chk(enc_cmd_pkg::op_gear_denom, `REG_DENOM, 32'h3e9,
              1'b0, 32'h3e8);
      set_chk(enc_cmd_pkg::op_gear_denom, `REG_DENOM, 32'hffff_ffff,
              1'b0, 32'h3e8);
      // every channel and function code
      for (int ch = 1; ch <= 2; ch++) begin
         for (int c = 1; c <= 3; c++) begin
            do_cmd(enc_cmd_pkg::op_analog_func, 1'b1, 2'(ch), 32'(c));
            if (ch == 1) af1 = 2'(c);
            else af2 = 2'(c);
            reject_is(1'b0);
            bus(1'b0, `REG_AFUNC, 32'h0);
            check(rdat, {22'h0, af2, 6'h0, af1});
            check({analog_input_one_ref, analog_input_one_gp, analog_input_two_trq, analog_input_two_gp},
                  {af1 == 2'h1, af1 == 2'h3,
                   af2 == 2'h2, af2 == 2'h3});
            do_cmd(enc_cmd_pkg::op_analog_func, 1'b0, 2'(ch), 32'h0);
            bus(1'b0, `REG_REPLY, 32'h0);
            check(rdat, 32'(c));
         end
      end
      do_cmd(enc_cmd_pkg::op_analog_func, 1'b1, 2'h1, 32'h0);
      reject_is(1'b1);
      do_cmd(enc_cmd_pkg::op_analog_func, 1'b1, 2'h2, 32'h4);
      reject_is(1'b1);
      do_cmd(enc_cmd_pkg::op_analog_func, 1'b1, 2'h3, 32'h1);
      reject_is(1'b1);
      bus(1'b0, `REG_AFUNC, 32'h0);
      check(rdat, 32'h303);
      results();
   end
endmodule // encoder_gearing_command_handler_tb
`default_nettype wire
